//--- rtl/ispj_pkg.sv
package ispj_pkg;

  // Serial instruction bytes.
  localparam logic [7:0] OPC_UNLOCK_B1  = 8'hAC;
  localparam logic [7:0] OPC_UNLOCK_B2  = 8'h53;
  localparam logic [7:0] OPC_ERASE_B2   = 8'h80;
  localparam logic [7:0] OPC_POLL       = 8'hF0;
  localparam logic [7:0] OPC_EXT_ADDR   = 8'h4D;
  localparam logic [7:0] OPC_LOAD_LO    = 8'h40;
  localparam logic [7:0] OPC_LOAD_HI    = 8'h48;
  localparam logic [7:0] OPC_EE_LOAD    = 8'hC1;
  localparam logic [7:0] OPC_READ_LO    = 8'h20;
  localparam logic [7:0] OPC_READ_HI    = 8'h28;
  localparam logic [7:0] OPC_COMMIT     = 8'h4C;
  localparam logic [7:0] OPC_EE_COMMIT  = 8'hC2;
  localparam logic [7:0] OPC_FUSE_RD_A  = 8'h50;
  localparam logic [7:0] OPC_FUSE_RD_B  = 8'h58;
  localparam logic [7:0] OPC_FUSE_SEL_0 = 8'h00;
  localparam logic [7:0] OPC_FUSE_SEL_8 = 8'h08;
  localparam logic [7:0] OPC_FUSE_WR_LO = 8'hA0;
  localparam logic [7:0] OPC_FUSE_WR_HI = 8'hA8;
  localparam logic [7:0] OPC_FUSE_WR_EX = 8'hA4;

  // Test port.
  localparam int         IR_W           = 4;
  localparam logic [3:0] IR_RESET_CHAIN = 4'hC;
  localparam logic [3:0] IR_UNLOCK      = 4'h4;
  localparam logic [3:0] IR_COMMAND     = 4'h5;
  localparam logic [3:0] IR_PAGELOAD    = 4'h6;
  localparam logic [3:0] IR_BYPASS      = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [15:0] UNLOCK_SIG    = 16'hA370;
  localparam int         CMD_W          = 15;
  localparam int         PAGE_BITS      = 1024;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;

  // Chip clocks of external reset before the disable bit drops.
  localparam logic [1:0] JTD_CLR_CLKS   = 2'h2;
  // High fuse bit that enables the test port when programmed (0).
  localparam int         JTAG_FUSE_BIT  = 6;

  // Register map, byte addresses.
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_FUSE       = 4'h8;
  localparam int         CTRL_JTD       = 0;
  localparam int         ST_PEND        = 0;
  localparam int         ST_SPI_UNL     = 1;
  localparam int         ST_JTAG_PROG   = 2;
  localparam int         ST_CORE_RST    = 3;

  typedef enum logic [3:0] {
    OP_NONE, OP_ERASE, OP_EXT_ADDR, OP_LOAD_LO, OP_LOAD_HI, OP_EE_LOAD,
    OP_READ_LO, OP_READ_HI, OP_COMMIT, OP_EE_COMMIT, OP_JTAG_CMD,
    OP_PAGE_BYTE
  } ispj_op_t;

  typedef struct packed {
    logic        valid;
    ispj_op_t    op;
    logic [15:0] addr;
    logic [7:0]  data;
  } ispj_mem_cmd_t;

  typedef enum logic [15:0] {
    TS_TLR  = 16'h0001, TS_RTI  = 16'h0002, TS_SELD = 16'h0004,
    TS_CAPD = 16'h0008, TS_SHD  = 16'h0010, TS_EX1D = 16'h0020,
    TS_PAUD = 16'h0040, TS_EX2D = 16'h0080, TS_UPDD = 16'h0100,
    TS_SELI = 16'h0200, TS_CAPI = 16'h0400, TS_SHI  = 16'h0800,
    TS_EX1I = 16'h1000, TS_PAUI = 16'h2000, TS_EX2I = 16'h4000,
    TS_UPDI = 16'h8000
  } ispj_tap_t;

endpackage

//--- rtl/ispj_prog_if.sv
// How it works
// RULE1 - Bytes AC 80 erase flash and EEPROM; last two bytes are zero.
// RULE2 - Poll F0 returns busy in bit 0; programmer waits for zero.
// RULE3 - Byte 4D loads extended address from the third byte.
// RULE4 - Bytes 40 and 48 load low and high page data bytes.
// RULE5 - Programmer loads the low byte before the high byte per word.
// RULE6 - Byte C1 loads one EEPROM page byte, address in third byte.
// RULE7 - Bytes 20 and 28 read program memory; data in fourth byte.
// RULE8 - Byte 4C commits the flash page; page from bytes two and three.
// RULE9 - Byte C2 commits the EEPROM page buffer at given address.
// RULE10 - Fuse reads 50 00, 58 08, 50 08 return value in byte four.
// RULE11 - Fuse writes AC A0, A8, A4 take new value from byte four.
// RULE12 - Fuse bits read 0 programmed, 1 unprogrammed; unused stay 1.
// RULE13 - Disable bit clears two chip clocks after external reset low.
// RULE14 - Every test shift register moves its least significant bit first.
// RULE15 - Four-bit instruction register; Run-Test/Idle drives internal clocks.
// RULE16 - Code C selects one-bit reset chain; the TAP is not reset.
// RULE17 - Device stays reset while the chain holds one, unlatched.
// RULE18 - Code 4 selects unlock register, compared on Update-DR.
// RULE19 - Code 5 command register: capture result, shift, apply on update.
// RULE20 - Each Run-Test/Idle under command code gives one internal clock.
// RULE21 - Code 6 streams page bytes from an eight-bit shifter.
// RULE22 - Programmer streams pages only when first in the scan chain.
// RULE23 - Serial unlock echoes second byte during the third byte.
// RULE24 - Unlock pattern A370 hex; unlock state cleared on reset.
// RULE25 - Serial decoder ignores all but unlock until unlocked.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module ispj_prog_if
  import ispj_pkg::*;
#(
  parameter logic [7:0] FUSE_LOW_RST  = 8'hFF,
  parameter logic [7:0] FUSE_HIGH_RST = 8'hBF,
  parameter logic [7:0] FUSE_EXT_RST  = 8'hFF,
  parameter int         PAGE_BYTES    = PAGE_BITS / 8
) (
  input  wire logic          MCLK,
  input  wire logic          NRST,
  input  wire logic          EXT_RESET_N,
  input  wire logic          SCK,
  input  wire logic          MOSI,
  output logic               MISO,
  input  wire logic          TCK,
  input  wire logic          TMS,
  input  wire logic          TDI,
  output logic               TDO,
  output logic               TDO_OE,
  input  wire logic [3:0]    AVS_ADDRESS,
  input  wire logic          AVS_READ,
  input  wire logic          AVS_WRITE,
  input  wire logic [31:0]   AVS_WRITEDATA,
  output logic [31:0]        AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  output ispj_mem_cmd_t      MEM_CMD,
  input  wire logic [7:0]    MEM_RDATA,
  input  wire logic          MEM_BUSY,
  output logic               CORE_RESET,
  output logic               PROG_MODE
);

  localparam int PIDX_W = $clog2(PAGE_BYTES);

  logic [1:0]        sck_s, mosi_s, rstp_s, tck_s, tms_s, tdi_s;
  logic              sck_d, tck_d;
  logic              sck_rise, sck_fall, tck_rise, tck_fall, spi_active;
  logic [31:0]       spi_sh_r, spi_nxt;
  logic [4:0]        bit_cnt_r;
  logic [7:0]        tx_r;
  logic              byte_end, word_end, byte3_end, rd_wait_r, unl_r;
  logic [7:0]        fuse_lo_r, fuse_hi_r, fuse_ex_r;
  ispj_mem_cmd_t     spi_cmd, jtag_cmd, mem_cmd_r;
  logic              jtd_r, ctrl_wr, wait_r;
  logic [1:0]        jtd_cnt_r;
  logic [31:0]       rdata_r;
  ispj_tap_t         tap_r;
  logic              tap_en;
  logic [IR_W-1:0]   ir_r, ir_sh_r;
  logic              byp_r, rst_chain_r, jprog_r, tdo_r, tdo_oe_r;
  logic [15:0]       unl_sh_r;
  logic [CMD_W-1:0]  cmd_sh_r, cmd_app_r;
  logic [7:0]        pl_sh_r;
  logic [2:0]        pl_cnt_r;
  logic [PIDX_W-1:0] pl_idx_r;
  logic              core_rst_r;
  logic              prog_mode_r;

  function automatic ispj_tap_t tap_next(ispj_tap_t s, logic tms);
    case (s)
      TS_TLR:  tap_next = tms ? TS_TLR  : TS_RTI;
      TS_RTI:  tap_next = tms ? TS_SELD : TS_RTI;
      TS_SELD: tap_next = tms ? TS_SELI : TS_CAPD;
      TS_CAPD: tap_next = tms ? TS_EX1D : TS_SHD;
      TS_SHD:  tap_next = tms ? TS_EX1D : TS_SHD;
      TS_EX1D: tap_next = tms ? TS_UPDD : TS_PAUD;
      TS_PAUD: tap_next = tms ? TS_EX2D : TS_PAUD;
      TS_EX2D: tap_next = tms ? TS_UPDD : TS_SHD;
      TS_UPDD: tap_next = tms ? TS_SELD : TS_RTI;
      TS_SELI: tap_next = tms ? TS_TLR  : TS_CAPI;
      TS_CAPI: tap_next = tms ? TS_EX1I : TS_SHI;
      TS_SHI:  tap_next = tms ? TS_EX1I : TS_SHI;
      TS_EX1I: tap_next = tms ? TS_UPDI : TS_PAUI;
      TS_PAUI: tap_next = tms ? TS_EX2I : TS_PAUI;
      TS_EX2I: tap_next = tms ? TS_UPDI : TS_SHI;
      TS_UPDI: tap_next = tms ? TS_SELD : TS_RTI;
      default: tap_next = TS_TLR;
    endcase
  endfunction

  // Every serial, test and reset pin crosses two flip-flops; a third stage finds the SCK and TCK edges.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sck_s  <= 2'h0;
      mosi_s <= 2'h0;
      rstp_s <= 2'h3;
      tck_s  <= 2'h0;
      tms_s  <= 2'h3;
      tdi_s  <= 2'h0;
      sck_d  <= 1'b0;
      tck_d  <= 1'b0;
    end else begin
      sck_s  <= {sck_s[0], SCK};
      mosi_s <= {mosi_s[0], MOSI};
      rstp_s <= {rstp_s[0], EXT_RESET_N};
      tck_s  <= {tck_s[0], TCK};
      tms_s  <= {tms_s[0], TMS};
      tdi_s  <= {tdi_s[0], TDI};
      sck_d  <= sck_s[1];
      tck_d  <= tck_s[1];
    end
  end

  assign sck_rise   = sck_s[1] & ~sck_d;
  assign sck_fall   = ~sck_s[1] & sck_d;
  assign tck_rise   = tck_s[1] & ~tck_d;
  assign tck_fall   = ~tck_s[1] & tck_d;
  assign spi_active = ~rstp_s[1];
  assign spi_nxt    = {spi_sh_r[30:0], mosi_s[1]};
  assign byte_end   = sck_rise && (bit_cnt_r[2:0] == BYTE_LAST_BIT);
  assign word_end   = byte_end && (bit_cnt_r[4:3] == 2'h3);
  assign byte3_end  = byte_end && (bit_cnt_r[4:3] == 2'h2);

  // Serial input is sampled on SCK rise, most significant bit first.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      spi_sh_r  <= 32'h0000_0000;
      bit_cnt_r <= 5'h00;
    end else if (!spi_active) begin
      spi_sh_r  <= 32'h0000_0000;
      bit_cnt_r <= 5'h00;
    end else if (sck_rise) begin
      spi_sh_r  <= spi_nxt;
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // Unlock lives only while external reset is held low.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      unl_r <= 1'b0;
    end else if (!spi_active) begin
      unl_r <= 1'b0;
    end else if (word_end && spi_nxt[31:24] == OPC_UNLOCK_B1
                 && spi_nxt[23:16] == OPC_UNLOCK_B2) begin
      unl_r <= 1'b1;
    end
  end

  // Reply byte: echo by default, read data in the fourth byte.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tx_r      <= 8'h00;
      MISO      <= 1'b0;
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= 1'b0;
      if (rd_wait_r) begin
        tx_r <= MEM_RDATA;
      end else if (byte3_end && unl_r) begin
        // RULE2 busy in bit 0
        if (spi_nxt[23:16] == OPC_POLL) begin
          tx_r <= {7'h00, MEM_BUSY};
        // RULE10 fuse read select
        end else if (spi_nxt[23:16] == OPC_FUSE_RD_A
                     && spi_nxt[15:8] == OPC_FUSE_SEL_0) begin
          tx_r <= fuse_lo_r;
        end else if (spi_nxt[23:16] == OPC_FUSE_RD_B
                     && spi_nxt[15:8] == OPC_FUSE_SEL_8) begin
          tx_r <= fuse_hi_r;
        end else if (spi_nxt[23:16] == OPC_FUSE_RD_A
                     && spi_nxt[15:8] == OPC_FUSE_SEL_8) begin
          tx_r <= fuse_ex_r;
        end else begin
          tx_r      <= spi_nxt[7:0];
          rd_wait_r <= (spi_nxt[23:16] == OPC_READ_LO)
                    || (spi_nxt[23:16] == OPC_READ_HI);
        end
      // RULE23 echo previous byte
      end else if (byte_end) begin
        tx_r <= spi_nxt[7:0];
      end else if (sck_fall) begin
        MISO <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // RULE25 gate on unlock
  always_comb begin
    spi_cmd = '0;
    if (word_end && unl_r) begin
      spi_cmd.addr = spi_nxt[23:8];
      spi_cmd.data = spi_nxt[7:0];
      case (spi_nxt[31:24])
        // RULE1 chip erase
        OPC_UNLOCK_B1: begin
          spi_cmd.valid = (spi_nxt[23:16] == OPC_ERASE_B2);
          spi_cmd.op    = OP_ERASE;
        end
        // RULE3 extended address
        OPC_EXT_ADDR: begin
          spi_cmd = '{1'b1, OP_EXT_ADDR, 16'h0000, spi_nxt[15:8]};
        end
        // RULE4 page data load
        OPC_LOAD_LO: begin
          spi_cmd.valid = 1'b1;
          spi_cmd.op    = OP_LOAD_LO;
        end
        OPC_LOAD_HI: begin
          spi_cmd.valid = 1'b1;
          spi_cmd.op    = OP_LOAD_HI;
        end
        // RULE6 EEPROM page byte
        OPC_EE_LOAD: begin
          spi_cmd.valid = 1'b1;
          spi_cmd.op    = OP_EE_LOAD;
          spi_cmd.addr  = {8'h00, spi_nxt[15:8]};
        end
        // RULE8 page number extract
        OPC_COMMIT: begin
          spi_cmd.valid = 1'b1;
          spi_cmd.op    = OP_COMMIT;
          spi_cmd.addr  = {9'h000, spi_nxt[20:16], spi_nxt[15:14]};
        end
        // RULE9 EEPROM page commit
        OPC_EE_COMMIT: begin
          spi_cmd.valid = 1'b1;
          spi_cmd.op    = OP_EE_COMMIT;
        end
        default: spi_cmd = '0;
      endcase
    // RULE7 read at third byte
    end else if (byte3_end && unl_r && (spi_nxt[23:16] == OPC_READ_LO
                 || spi_nxt[23:16] == OPC_READ_HI)) begin
      spi_cmd.valid = 1'b1;
      spi_cmd.op    = (spi_nxt[23:16] == OPC_READ_HI) ? OP_READ_HI
                                                      : OP_READ_LO;
      spi_cmd.addr  = spi_nxt[15:0];
    end
  end

  // RULE11 fuse writes
  // RULE12 reset unprogrammed except high fuse bit 6
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      fuse_lo_r <= FUSE_LOW_RST;
      fuse_hi_r <= FUSE_HIGH_RST;
      fuse_ex_r <= FUSE_EXT_RST;
    end else if (word_end && unl_r
                 && spi_nxt[31:24] == OPC_UNLOCK_B1) begin
      if (spi_nxt[23:16] == OPC_FUSE_WR_LO) begin
        fuse_lo_r <= spi_nxt[7:0];
      end else if (spi_nxt[23:16] == OPC_FUSE_WR_HI) begin
        fuse_hi_r <= spi_nxt[7:0];
      end else if (spi_nxt[23:16] == OPC_FUSE_WR_EX) begin
        fuse_ex_r <= spi_nxt[7:0];
      end
    end
  end

  // The serial side wins a same-cycle clash; both hosts at once is misuse.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mem_cmd_r <= '0;
    end else if (spi_cmd.valid) begin
      mem_cmd_r <= spi_cmd;
    end else begin
      mem_cmd_r <= jtag_cmd;
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge.
  assign ctrl_wr = AVS_WRITE && !wait_r && (AVS_ADDRESS == REG_CTRL);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= !((AVS_READ || AVS_WRITE) && wait_r);
      if (AVS_READ && wait_r) begin
        if (AVS_ADDRESS == REG_CTRL) begin
          rdata_r <= {31'h0000_0000, jtd_r};
        end else if (AVS_ADDRESS == REG_STATUS) begin
          rdata_r <= {28'h000_0000, core_rst_r, jprog_r, unl_r, MEM_BUSY};
        end else if (AVS_ADDRESS == REG_FUSE) begin
          rdata_r <= {8'h00, fuse_ex_r, fuse_hi_r, fuse_lo_r};
        end else begin
          rdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // RULE13 disable bit auto-clear
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      jtd_r     <= 1'b0;
      jtd_cnt_r <= 2'h0;
    end else if (ctrl_wr) begin
      jtd_r     <= AVS_WRITEDATA[CTRL_JTD];
      jtd_cnt_r <= 2'h0;
    end else if (jtd_r && spi_active) begin
      jtd_cnt_r <= jtd_cnt_r + 2'h1;
      if (jtd_cnt_r == JTD_CLR_CLKS - 2'h1) begin
        jtd_r <= 1'b0;
      end
    end else begin
      jtd_cnt_r <= 2'h0;
    end
  end

  assign tap_en = !jtd_r && !fuse_hi_r[JTAG_FUSE_BIT];

  // RULE16 TAP kept apart from the reset chain
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tap_r <= TS_TLR;
    end else if (!tap_en) begin
      tap_r <= TS_TLR;
    end else if (tck_rise) begin
      tap_r <= tap_next(tap_r, tms_s[1]);
    end
  end

  // RULE14 shift right, LSB first
  // RULE15 four-bit instruction register
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ir_r    <= IR_BYPASS;
      ir_sh_r <= IR_BYPASS;
    end else if (tap_r == TS_TLR) begin
      ir_r <= IR_BYPASS;
    end else if (tck_rise) begin
      if (tap_r == TS_CAPI) begin
        ir_sh_r <= IR_CAPTURE_VAL;
      end else if (tap_r == TS_SHI) begin
        ir_sh_r <= {tdi_s[1], ir_sh_r[IR_W-1:1]};
      end else if (tap_r == TS_UPDI) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // Data registers; Update-DR of the unlock chain sets programming mode.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      byp_r       <= 1'b0;
      rst_chain_r <= 1'b0;
      unl_sh_r    <= 16'h0000;
      jprog_r     <= 1'b0;
      cmd_sh_r    <= '0;
      cmd_app_r   <= '0;
    end else if (tck_rise) begin
      if (tap_r == TS_SHD) begin
        byp_r <= tdi_s[1];
        // RULE17 chain value unlatched
        if (ir_r == IR_RESET_CHAIN) begin
          rst_chain_r <= tdi_s[1];
        end
        if (ir_r == IR_UNLOCK) begin
          unl_sh_r <= {tdi_s[1], unl_sh_r[15:1]};
        end
        if (ir_r == IR_COMMAND) begin
          cmd_sh_r <= {tdi_s[1], cmd_sh_r[CMD_W-1:1]};
        end
      end
      // RULE19 capture previous result
      if (tap_r == TS_CAPD && ir_r == IR_COMMAND) begin
        cmd_sh_r <= {7'h00, MEM_RDATA};
      end
      if (tap_r == TS_UPDD && ir_r == IR_COMMAND) begin
        cmd_app_r <= cmd_sh_r;
      end
      // RULE18 compare on update
      // RULE24 fixed signature
      if (tap_r == TS_UPDD && ir_r == IR_UNLOCK) begin
        jprog_r <= (unl_sh_r == UNLOCK_SIG);
      end
    end
  end

  // RULE21 byte-wise page stream
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pl_sh_r  <= 8'h00;
      pl_cnt_r <= 3'h0;
      pl_idx_r <= '0;
    end else if (tck_rise && ir_r == IR_PAGELOAD) begin
      if (tap_r == TS_CAPD) begin
        pl_cnt_r <= 3'h0;
        pl_idx_r <= '0;
      end else if (tap_r == TS_SHD) begin
        pl_sh_r  <= {tdi_s[1], pl_sh_r[7:1]};
        pl_cnt_r <= pl_cnt_r + 3'h1;
        if (pl_cnt_r == BYTE_LAST_BIT) begin
          pl_idx_r <= pl_idx_r + 1'b1;
        end
      end
    end
  end

  always_comb begin
    jtag_cmd = '0;
    // RULE20 one clock per idle cycle
    if (tck_rise && jprog_r && tap_r == TS_RTI && ir_r == IR_COMMAND) begin
      jtag_cmd = '{1'b1, OP_JTAG_CMD, {1'b0, cmd_app_r}, 8'h00};
    end else if (tck_rise && jprog_r && tap_r == TS_SHD
                 && ir_r == IR_PAGELOAD && pl_cnt_r == BYTE_LAST_BIT) begin
      jtag_cmd.valid = 1'b1;
      jtag_cmd.op    = OP_PAGE_BYTE;
      jtag_cmd.addr  = 16'(pl_idx_r);
      jtag_cmd.data  = {tdi_s[1], pl_sh_r[7:1]};
    end
  end

  // TDO changes on the falling TCK edge so the far end samples it stable.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (tap_r == TS_SHD) || (tap_r == TS_SHI);
      if (tap_r == TS_SHI) begin
        tdo_r <= ir_sh_r[0];
      end else if (ir_r == IR_RESET_CHAIN) begin
        tdo_r <= rst_chain_r;
      end else if (ir_r == IR_UNLOCK) begin
        tdo_r <= unl_sh_r[0];
      end else if (ir_r == IR_COMMAND) begin
        tdo_r <= cmd_sh_r[0];
      end else if (ir_r == IR_PAGELOAD) begin
        tdo_r <= pl_sh_r[0];
      end else begin
        tdo_r <= byp_r;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      core_rst_r <= 1'b1;
    end else begin
      core_rst_r <= rst_chain_r || spi_active;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      prog_mode_r <= 1'b0;
    end else begin
      prog_mode_r <= jprog_r || unl_r;
    end
  end

  assign TDO             = tdo_r;
  assign TDO_OE          = tdo_oe_r;
  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign MEM_CMD         = mem_cmd_r;
  assign CORE_RESET      = core_rst_r;
  assign PROG_MODE       = prog_mode_r;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence rst_held_s;
    (spi_active && !ctrl_wr) [*4];
  endsequence

  erase_issue_a: assert property ( // RULE1
    word_end && unl_r && spi_nxt[31:16] == {OPC_UNLOCK_B1, OPC_ERASE_B2}
    |=> MEM_CMD.valid && MEM_CMD.op == OP_ERASE)
    else $error("Erase instruction not issued.");

  poll_reply_a: assert property ( // RULE2
    byte3_end && unl_r && spi_nxt[23:16] == OPC_POLL
    |=> tx_r == {7'h00, $past(MEM_BUSY)})
    else $error("Poll reply does not carry busy.");

  page_commit_a: assert property ( // RULE8
    word_end && unl_r && spi_nxt[31:24] == OPC_COMMIT
    |=> MEM_CMD.op == OP_COMMIT
        && MEM_CMD.addr[6:0] == $past({spi_nxt[20:16], spi_nxt[15:14]}))
    else $error("Page commit address wrong.");

  locked_ignore_a: assert property ( // RULE25
    word_end && !unl_r && !jtag_cmd.valid |=> !MEM_CMD.valid)
    else $error("Locked decoder issued a command.");

  unlock_echo_a: assert property ( // RULE23
    byte_end && bit_cnt_r[4:3] == 2'h1 |=> tx_r == $past(spi_nxt[7:0]))
    else $error("Second byte not echoed.");

  jtd_clear_a: assert property ( // RULE13
    rst_held_s |-> !jtd_r)
    else $error("Disable bit not cleared under reset.");

  unlock_cmp_a: assert property ( // RULE18
    tck_rise && tap_r == TS_UPDD && ir_r == IR_UNLOCK
    |=> jprog_r == ($past(unl_sh_r) == UNLOCK_SIG))
    else $error("Unlock compare wrong.");

  chain_reset_a: assert property ( // RULE17
    rst_chain_r |=> CORE_RESET)
    else $error("Reset chain did not hold reset.");

  idle_clock_a: assert property ( // RULE20
    tck_rise && jprog_r && tap_r == TS_RTI && ir_r == IR_COMMAND
    && !spi_cmd.valid |=> MEM_CMD.valid && MEM_CMD.op == OP_JTAG_CMD)
    else $error("Idle state gave no command clock.");

endmodule

//--- bench/ispj_isp_model.sv
`timescale 1ns/1ps
module ispj_isp_model (
  input  wire logic MCLK,
  output logic      SCK,
  output logic      MOSI,
  input  wire logic MISO,
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO,
  input  wire logic TDO_OE
);
  initial begin
    SCK = 1'b0;
    MOSI = 1'b0;
    TCK = 1'b0;
    TMS = 1'b0;
    TDI = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      MOSI <= w[i];
      repeat (8) @(posedge MCLK);
      SCK <= 1'b1;
      r[i] = MISO;
      repeat (8) @(posedge MCLK);
      SCK <= 1'b0;
    end
    // A released line shows the inverse so a stale bit is never trusted.
    MOSI <= ~w[0];
    repeat (8) @(posedge MCLK);
  endtask
  task automatic jb(input logic ms, input logic di, output logic o);
    TMS <= ms;
    TDI <= di;
    repeat (8) @(posedge MCLK);
    TCK <= 1'b1;
    o = TDO & TDO_OE;
    repeat (8) @(posedge MCLK);
    TCK <= 1'b0;
  endtask
  // Shifts n bits through IR or DR, starting and ending in Run-Test/Idle.
  task automatic js(input logic ir, input int n, input logic [15:0] v,
                    output logic [15:0] o);
    logic b;
    jb(1'b1, 1'b0, b);
    if (ir) jb(1'b1, 1'b0, b);
    jb(1'b0, 1'b0, b);
    jb(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) jb(i == n - 1, v[i], o[i]);
    jb(1'b1, 1'b0, b);
    jb(1'b0, 1'b0, b);
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ispj_pkg::*;
  typedef struct packed {
    logic [31:0] w;
    ispj_op_t    op;
    logic [23:0] m;
    logic [23:0] ad;
    logic [8:0]  rp;
  } ispj_row_t;
  logic          MCLK = 1'b0;
  logic          NRST = 1'b0;
  logic          EXT_RESET_N = 1'b1;
  logic          MEM_BUSY = 1'b0;
  logic [7:0]    mrd = 8'h5A;
  logic          SCK, MOSI, MISO, TDO, TDO_OE, CORE_RESET, PROG_MODE;
  logic          TCK, TMS, TDI;
  logic [3:0]    AVS_ADDRESS = 4'h0;
  logic          AVS_READ = 1'b0;
  logic          AVS_WRITE = 1'b0;
  logic [31:0]   AVS_WRITEDATA = 32'h0;
  logic [31:0]   AVS_READDATA, q, r, n, errors, checked, cyc, ncmd;
  logic          AVS_WAITREQUEST;
  ispj_mem_cmd_t MEM_CMD, cmd;
  logic [15:0]   fr [3] = '{16'h5000, 16'h5808, 16'h5008};
  logic [7:0]    fw [3] = '{8'hA0, 8'hA8, 8'hA4};
  logic [7:0]    fv [3] = '{8'hFF, 8'hBF, 8'hFF};
  logic [7:0]    fn [3] = '{8'hE2, 8'h99, 8'hFD};
  ispj_row_t     rows [9] = '{
    '{32'hAC800000, OP_ERASE, 24'h0, 24'h0, 9'h0},
    '{32'h4D001200, OP_EXT_ADDR, 24'hFFFFFF, 24'h000012, 9'h0},
    '{32'h40012355, OP_LOAD_LO, 24'hFFFFFF, 24'h012355, 9'h0},
    '{32'h480123AA, OP_LOAD_HI, 24'hFFFFFF, 24'h0123AA, 9'h0},
    '{32'hC1003466, OP_EE_LOAD, 24'h00FFFF, 24'h003466, 9'h0},
    '{32'h20045600, OP_READ_LO, 24'hFFFF00, 24'h045600, 9'h15A},
    '{32'h28045600, OP_READ_HI, 24'hFFFF00, 24'h045600, 9'h15A},
    '{32'h4C1FC000, OP_COMMIT, 24'hFFFFFF, 24'h007F00, 9'h0},
    '{32'hC2012300, OP_EE_COMMIT, 24'hFFFFFF, 24'h012300, 9'h0}};

  ispj_isp_model pm (.MCLK(MCLK), .SCK(SCK), .MOSI(MOSI), .MISO(MISO),
    .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE));
  ispj_prog_if uut (
    .MCLK(MCLK), .NRST(NRST), .EXT_RESET_N(EXT_RESET_N), .SCK(SCK),
    .MOSI(MOSI), .MISO(MISO), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO(TDO), .TDO_OE(TDO_OE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEM_CMD(MEM_CMD),
    .MEM_RDATA(mrd), .MEM_BUSY(MEM_BUSY), .CORE_RESET(CORE_RESET),
    .PROG_MODE(PROG_MODE));

  always #5 MCLK = ~MCLK;

  initial begin
    cyc = 0;
    ncmd = 0;
    errors = 0;
    checked = 0;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (MEM_CMD.valid === 1'b1) begin
      cmd <= MEM_CMD;
      ncmd <= ncmd + 1;
    end
    if (cyc == 40000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic final_report();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked != 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge MCLK);
    chk({CORE_RESET, PROG_MODE, AVS_WAITREQUEST}, 32'h5);
    NRST <= 1'b1;
    av(1'b0, REG_FUSE, 32'h0);
    chk(q, 32'h00FFBFFF);
    av(1'b1, REG_CTRL, 32'h1);
    av(1'b0, REG_CTRL, 32'h0);
    chk(q[CTRL_JTD], 32'h1);
    EXT_RESET_N <= 1'b0;
    repeat (10) @(posedge MCLK);
    av(1'b0, REG_CTRL, 32'h0);
    chk(q[CTRL_JTD], 32'h0);
    av(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    n = ncmd;
    pm.xfer(32'hAC800000, r);
    chk(ncmd, n);
    pm.xfer(32'hAC530000, r);
    chk(r[15:8], OPC_UNLOCK_B2);
    chk({PROG_MODE, CORE_RESET}, 32'h3);
    foreach (rows[i]) begin
      n = ncmd;
      pm.xfer(rows[i].w, r);
      chk(ncmd, n + 1);
      chk(cmd.op, rows[i].op);
      chk({cmd.addr, cmd.data} & rows[i].m, rows[i].ad & rows[i].m);
      if (rows[i].rp[8]) chk(r[7:0], rows[i].rp[7:0]);
    end
    for (int k = 0; k < 3; k++) begin
      pm.xfer({fr[k], 16'h0}, r);
      chk(r[7:0], fv[k]);
      pm.xfer({8'hAC, fw[k], 8'h0, fn[k]}, r);
      pm.xfer({fr[k], 16'h0}, r);
      chk(r[7:0], fn[k]);
    end
    av(1'b0, REG_FUSE, 32'h0);
    chk(q, {8'h0, fn[2], fn[1], fn[0]});
    MEM_BUSY <= 1'b1;
    pm.xfer(32'hF0000000, r);
    chk(r[0], 32'h1);
    MEM_BUSY <= 1'b0;
    pm.xfer(32'hF0000000, r);
    chk(r[0], 32'h0);
    EXT_RESET_N <= 1'b1;
    repeat (10) @(posedge MCLK);
    chk(PROG_MODE, 32'h0);
    pm.jb(1'b0, 1'b0, r[0]);
    pm.js(1'b1, 4, 16'(IR_UNLOCK), r[15:0]);
    chk(r[3:0], IR_CAPTURE_VAL);
    pm.js(1'b0, 16, UNLOCK_SIG ^ 16'h1, r[15:0]);
    chk(PROG_MODE, 32'h0);
    pm.js(1'b0, 16, UNLOCK_SIG, r[15:0]);
    chk({PROG_MODE, r[15:0]}, {1'b1, UNLOCK_SIG ^ 16'h1});
    pm.js(1'b1, 4, 16'(IR_RESET_CHAIN), r[15:0]);
    pm.js(1'b0, 1, 16'h1, r[15:0]);
    chk(CORE_RESET, 32'h1);
    pm.js(1'b0, 1, 16'h0, r[15:0]);
    chk({CORE_RESET, r[0]}, 32'h1);
    pm.js(1'b1, 4, 16'(IR_COMMAND), r[15:0]);
    pm.js(1'b0, 15, 16'h2355, r[15:0]);
    n = ncmd;
    pm.jb(1'b0, 1'b0, r[0]);
    chk(ncmd, n + 1);
    chk({cmd.op, cmd.addr}, {OP_JTAG_CMD, 16'h2355});
    pm.js(1'b1, 4, 16'(IR_PAGELOAD), r[15:0]);
    n = ncmd;
    pm.js(1'b0, 16, 16'hC3A5, r[15:0]);
    chk(ncmd, n + 2);
    chk({cmd.addr, cmd.data}, 24'h0001C3);
    EXT_RESET_N <= 1'b0;
    repeat (10) @(posedge MCLK);
    n = ncmd;
    pm.xfer(32'h40012355, r);
    chk(ncmd, n);
    final_report();
  end
endmodule
